// file: touch_adc_buffer_ref_ctrl.sv
// Function
// - enable bit low disables queue, resets read, write, trigger pointers
// - run select: 0 continuous conversion, 1 single shot; resets 0
// - trigger depth equals 8 * (code + 1) entries
// - full flag reads 1 only with 64 unread results
// - empty flag reads 1 with no unread result; resets 1
// - source select: 0 external, 1 internal reference; resets 0
// - settle code delays measurements 0, 100, 500, 1000 microseconds
// - settle delay applies only for internal sleeping reference
// - sleep bit 0 keeps reference on, 1 sleeps between conversions
// - external source keeps internal reference powered down always
// - level bit selects 1.25 V when 0, 2.50 V when 1
// - writing 0xbb00 to soft reset returns all control to defaults
// - new-data and ready flags are invalid while queue mode active
`timescale 1ns/100ps
module touch_adc_buffer_ref_ctrl (
  input wire logic clock, // system clock, 200 MHz
  input wire logic resetn, // async reset, active low
  input wire tarbc_pkg::tarbc_req_t req, // register port request
  output logic [15:0] rdata, // registered read data
  output logic rvalid, // read data valid pulse
  input wire tarbc_pkg::tarbc_queue_t queue, // unread results in queue
  input wire logic conversion_start, // converter begins a conversion
  input wire logic [8:0] new_data_in, // per-register new-data bits
  input wire logic result_ready_in, // data available from converter
  output logic queue_mode, // queue mode enabled
  output logic queue_pointer_clear, // hold read/write/trigger ptrs
  output logic queue_run_select, // 0 continuous, 1 single shot
  output logic [6:0] queue_trigger_level, // trigger depth in entries
  output logic queue_trigger, // unread count reached depth
  output logic internal_reference_on, // internal reference powered
  output logic internal_reference_level, // 0 1.25 V, 1 2.50 V
  output logic reference_settled, // measurement may start
  output logic [8:0] new_data_valid, // new-data bits, masked
  output logic result_ready_flag // data available, masked
);
  tarbc_pkg::tarbc_ctrl_t ctrl;
  tarbc_pkg::tarbc_ctrl_t next_ctrl;
  tarbc_pkg::tarbc_ctrl_t ctrl_default;
  logic [15:0] soft_reg;
  logic [15:0] next_soft_reg;
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic full;
  logic empty;
  logic soft_hit;
  logic settle_apply;
  logic reference_wanted;

  // power-up defaults of the control fields
  always_comb begin
    ctrl_default.queue_enable_clear = tarbc_pkg::rst_queue_enable_clear;
    ctrl_default.queue_run_select = tarbc_pkg::rst_queue_run_select;
    ctrl_default.queue_trigger_depth = tarbc_pkg::rst_queue_trigger_depth;
    ctrl_default.reserved_ref = tarbc_pkg::rst_reserved_ref;
    ctrl_default.reference_source_select =
      tarbc_pkg::rst_reference_source_select;
    ctrl_default.reference_settle_delay =
      tarbc_pkg::rst_reference_settle_delay;
    ctrl_default.reference_sleep_between =
      tarbc_pkg::rst_reference_sleep_between;
    ctrl_default.internal_reference_level =
      tarbc_pkg::rst_internal_reference_level;
  end

  assign soft_hit = req.wr && (req.addr == tarbc_pkg::addr_soft_reset_control)
    && (req.wdata == tarbc_pkg::soft_reset_code);

  // register writes; soft reset code overrides everything
  always_comb begin
    next_ctrl = ctrl;
    next_soft_reg = soft_reg;
    if (soft_hit) begin
      next_ctrl = ctrl_default;
      next_soft_reg = tarbc_pkg::rst_soft_reset_control;
    end else if (req.wr) begin
      case (req.addr)
        tarbc_pkg::addr_buffer_control: begin
          // flag and reserved bits are not stored
          next_ctrl.queue_enable_clear =
            req.wdata[tarbc_pkg::pos_queue_enable_clear];
          next_ctrl.queue_run_select =
            req.wdata[tarbc_pkg::pos_queue_run_select];
          next_ctrl.queue_trigger_depth =
            req.wdata[tarbc_pkg::pos_queue_trigger_depth +: 3];
        end
        tarbc_pkg::addr_reference_control: begin
          next_ctrl.reserved_ref =
            req.wdata[tarbc_pkg::pos_reserved_ref];
          next_ctrl.reference_source_select =
            req.wdata[tarbc_pkg::pos_reference_source_select];
          next_ctrl.reference_settle_delay =
            req.wdata[tarbc_pkg::pos_reference_settle_delay +: 2];
          next_ctrl.reference_sleep_between =
            req.wdata[tarbc_pkg::pos_reference_sleep_between];
          next_ctrl.internal_reference_level =
            req.wdata[tarbc_pkg::pos_internal_reference_level];
        end
        tarbc_pkg::addr_soft_reset_control: begin
          next_soft_reg = req.wdata; // other codes only stored
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  // control registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl.queue_enable_clear <= tarbc_pkg::rst_queue_enable_clear;
      ctrl.queue_run_select <= tarbc_pkg::rst_queue_run_select;
      ctrl.queue_trigger_depth <= tarbc_pkg::rst_queue_trigger_depth;
      ctrl.reserved_ref <= tarbc_pkg::rst_reserved_ref;
      ctrl.reference_source_select <= tarbc_pkg::rst_reference_source_select;
      ctrl.reference_settle_delay <= tarbc_pkg::rst_reference_settle_delay;
      ctrl.reference_sleep_between <= tarbc_pkg::rst_reference_sleep_between;
      ctrl.internal_reference_level <=
        tarbc_pkg::rst_internal_reference_level;
      soft_reg <= tarbc_pkg::rst_soft_reset_control;
    end else begin
      ctrl <= next_ctrl;
      soft_reg <= next_soft_reg;
    end
  end

  // read mux; reserved bits read zero except reserved_ref, which reads back as stored; flags show the status registered one cycle earlier in u_flags
  always_comb begin
    next_rdata = 16'h0;
    next_rvalid = req.rd;
    if (req.rd) begin
      case (req.addr)
        tarbc_pkg::addr_buffer_control: begin
          next_rdata[tarbc_pkg::pos_queue_enable_clear] =
            ctrl.queue_enable_clear;
          next_rdata[tarbc_pkg::pos_queue_run_select] = ctrl.queue_run_select;
          next_rdata[tarbc_pkg::pos_queue_trigger_depth +: 3] =
            ctrl.queue_trigger_depth;
          next_rdata[tarbc_pkg::pos_queue_full_flag] = full;
          next_rdata[tarbc_pkg::pos_queue_empty_flag] = empty;
        end
        tarbc_pkg::addr_reference_control: begin
          next_rdata[tarbc_pkg::pos_reserved_ref] = ctrl.reserved_ref;
          next_rdata[tarbc_pkg::pos_reference_source_select] =
            ctrl.reference_source_select;
          next_rdata[tarbc_pkg::pos_reference_settle_delay +: 2] =
            ctrl.reference_settle_delay;
          next_rdata[tarbc_pkg::pos_reference_sleep_between] =
            ctrl.reference_sleep_between;
          next_rdata[tarbc_pkg::pos_internal_reference_level] =
            ctrl.internal_reference_level;
        end
        tarbc_pkg::addr_soft_reset_control: begin
          next_rdata = soft_reg;
        end
        default: begin
          next_rdata = 16'h0;
        end
      endcase
    end
  end

  // read data registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 16'h0;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // queue control outputs
  assign queue_mode = ctrl.queue_enable_clear;
  assign queue_pointer_clear = !ctrl.queue_enable_clear;
  assign queue_run_select = ctrl.queue_run_select;

  tarbc_queue_flags u_flags (
    .clock(clock),
    .resetn(resetn),
    .enable(ctrl.queue_enable_clear),
    .depth_code(ctrl.queue_trigger_depth),
    .unread_count(queue.unread_count),
    .full(full),
    .empty(empty),
    .trigger(queue_trigger),
    .depth(queue_trigger_level)
  );

  // status bits that do not apply in queue mode read zero
  assign new_data_valid = ctrl.queue_enable_clear ? 9'h0
    : new_data_in;
  assign result_ready_flag = !ctrl.queue_enable_clear
    && result_ready_in;

  // reference power: external source forces internal off
  assign reference_wanted = !ctrl.reference_sleep_between
    || conversion_start;
  assign internal_reference_on = ctrl.reference_source_select
    && reference_wanted;
  assign internal_reference_level = ctrl.internal_reference_level;

  // settling delay only for internal reference that sleeps
  assign settle_apply = ctrl.reference_source_select
    && ctrl.reference_sleep_between;

  tarbc_settle_timer #(
    .settle_cycles_1(tarbc_pkg::settle_cycles_1),
    .settle_cycles_2(tarbc_pkg::settle_cycles_2),
    .settle_cycles_3(tarbc_pkg::settle_cycles_3)
  ) u_settle (
    .clock(clock),
    .resetn(resetn),
    .start(conversion_start),
    .apply(settle_apply),
    .select(ctrl.reference_settle_delay),
    .settled(reference_settled)
  );
endmodule

// file: tarbc_pkg.sv
package tarbc_pkg;
  // register addresses on the device register port
  localparam logic [5:0] addr_buffer_control = 6'h02;
  localparam logic [5:0] addr_reference_control = 6'h03;
  localparam logic [5:0] addr_soft_reset_control = 6'h04;
  // buffer control field positions
  localparam int pos_queue_enable_clear = 15;
  localparam int pos_queue_run_select = 14;
  localparam int pos_queue_trigger_depth = 11;
  localparam int pos_queue_full_flag = 10;
  localparam int pos_queue_empty_flag = 9;
  // reference control field positions
  localparam int pos_reserved_ref = 5;
  localparam int pos_reference_source_select = 4;
  localparam int pos_reference_settle_delay = 2;
  localparam int pos_reference_sleep_between = 1;
  localparam int pos_internal_reference_level = 0;
  // reset values
  localparam logic rst_queue_enable_clear = 1'h0;
  localparam logic rst_queue_run_select = 1'h0;
  localparam logic [2:0] rst_queue_trigger_depth = 3'h0;
  localparam logic rst_reserved_ref = 1'h0;
  localparam logic rst_reference_source_select = 1'h0;
  localparam logic [1:0] rst_reference_settle_delay = 2'h0;
  localparam logic rst_reference_sleep_between = 1'h1;
  localparam logic rst_internal_reference_level = 1'h0;
  localparam logic [15:0] rst_soft_reset_control = 16'hffff;
  localparam logic [15:0] soft_reset_code = 16'hbb00;
  // queue size
  localparam logic [6:0] queue_capacity = 7'h40;
  // settling times in microseconds and cycle counts at 200 MHz
  localparam int clock_mhz = 200;
  localparam int settle_us_1 = 100;
  localparam int settle_us_2 = 500;
  localparam int settle_us_3 = 1000;
  localparam int settle_cycles_1 = settle_us_1 * clock_mhz;
  localparam int settle_cycles_2 = settle_us_2 * clock_mhz;
  localparam int settle_cycles_3 = settle_us_3 * clock_mhz;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } tarbc_req_t;

  // control fields held by the block
  typedef struct packed {
    logic queue_enable_clear;
    logic queue_run_select;
    logic [2:0] queue_trigger_depth;
    logic reserved_ref;
    logic reference_source_select;
    logic [1:0] reference_settle_delay;
    logic reference_sleep_between;
    logic internal_reference_level;
  } tarbc_ctrl_t;

  // converter-side queue status
  typedef struct packed {
    logic [6:0] unread_count;
  } tarbc_queue_t;
endpackage

// file: tarbc_settle_timer.sv
`timescale 1ns/100ps
// counts the reference settling delay after a power-up request
module tarbc_settle_timer #(
  parameter int settle_cycles_1 = 20000,
  parameter int settle_cycles_2 = 100000,
  parameter int settle_cycles_3 = 200000
) (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic start, // reference power-up pulse
  input wire logic apply, // delay applies in this mode
  input wire logic [1:0] select, // settling code
  output logic settled // measurements may proceed
);
  logic [17:0] count;
  logic [17:0] next_count;
  logic [17:0] load;

  // pick the count for the selected settling code
  always_comb begin
    case (select)
      2'h1: load = 18'(settle_cycles_1);
      2'h2: load = 18'(settle_cycles_2);
      2'h3: load = 18'(settle_cycles_3);
      default: load = 18'h0;
    endcase
    next_count = count;
    if (start && apply) begin
      next_count = load;
    end else if (!apply) begin
      next_count = 18'h0;
    end else if (count != 18'h0) begin
      next_count = count - 18'h1;
    end
  end

  // counter register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= 18'h0;
    end else begin
      count <= next_count;
    end
  end

  // settled at once when the delay does not apply, even mid-count
  assign settled = !apply
    || ((count == 18'h0) && !(start && load != 18'h0));
endmodule

// file: tarbc_queue_flags.sv
`timescale 1ns/100ps
// derives full, empty and trigger flags from the unread count
module tarbc_queue_flags (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic enable, // queue mode on
  input wire logic [2:0] depth_code, // trigger depth code
  input wire logic [6:0] unread_count, // unread results held
  output logic full, // 64 unread results
  output logic empty, // no unread result
  output logic trigger, // count reached trigger depth
  output logic [6:0] depth // trigger depth in entries
);
  logic next_full;
  logic next_empty;
  logic next_trigger;

  // compute flags; a disabled queue reads empty
  always_comb begin
    depth = 7'({depth_code, 3'h0}) + 7'h8;
    next_full = enable
      && (unread_count == tarbc_pkg::queue_capacity);
    next_empty = !enable || (unread_count == 7'h0);
    next_trigger = enable && (unread_count >= depth);
  end

  // flag registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      full <= 1'b0;
      empty <= 1'b1;
      trigger <= 1'b0;
    end else begin
      full <= next_full;
      empty <= next_empty;
      trigger <= next_trigger;
    end
  end
endmodule

// file: tarbc_properties.sv
`timescale 1ns/100ps
// watches control outputs against the register writes that set them
module tarbc_properties (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire tarbc_pkg::tarbc_req_t req, // register request
  input wire logic rvalid, // read pulse
  input wire logic queue_mode, // queue on
  input wire logic queue_pointer_clear, // pointers held
  input wire logic queue_run_select, // run mode
  input wire logic [6:0] queue_trigger_level, // depth in entries
  input wire logic internal_reference_on, // reference powered
  input wire logic internal_reference_level, // reference level
  input wire logic reference_settled, // settling done
  input wire logic [8:0] new_data_valid, // masked new-data bits
  input wire logic result_ready_flag // masked ready flag
);
  logic [15:0] wd_q;
  wire w2 = req.wr && req.addr == tarbc_pkg::addr_buffer_control;
  wire w3 = req.wr && req.addr == tarbc_pkg::addr_reference_control;
  wire w4 = req.wr && req.addr == tarbc_pkg::addr_soft_reset_control;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // write data of the previous cycle
  always_ff @(posedge clock) wd_q <= req.wdata;
  mode_write_a: assert property (w2 |=> queue_mode == wd_q[15] &&
    queue_run_select == wd_q[14]) else $error("queue mode not taken");
  ptr_clear_a: assert property (queue_pointer_clear == !queue_mode)
    else $error("pointer clear wrong");
  depth_map_a: assert property (w2 |=>
    queue_trigger_level == {wd_q[13:11] + 4'h1, 3'h0})
    else $error("trigger depth wrong");
  ext_off_a: assert property (w3 && !req.wdata[4] |=>
    !internal_reference_on) else $error("external mode ref on");
  ref_awake_a: assert property (
    w3 && req.wdata[4] && !req.wdata[1] |=> internal_reference_on)
    else $error("reference not kept on");
  level_take_a: assert property (w3 |=>
    internal_reference_level == wd_q[0]) else $error("level not taken");
  settle_skip_a: assert property (
    w3 && !(req.wdata[4] && req.wdata[1]) |=> reference_settled)
    else $error("settle delay applied");
  soft_rst_a: assert property (w4 && req.wdata == 16'hbb00 |=>
    !queue_mode && !internal_reference_level && queue_trigger_level == 7'h08)
    else $error("soft reset missed");
  status_mask_a: assert property (
    queue_mode |-> new_data_valid == 9'h0 && !result_ready_flag)
    else $error("status not masked");
  read_pulse_a: assert property (rvalid == $past(req.rd))
    else $error("read pulse wrong");
endmodule
bind touch_adc_buffer_ref_ctrl tarbc_properties chk_i (.clock, .resetn,
  .req, .rvalid, .queue_mode, .queue_pointer_clear, .queue_run_select,
  .queue_trigger_level, .internal_reference_on, .internal_reference_level,
  .reference_settled, .new_data_valid, .result_ready_flag);

// file: tarbc_host.sv
`timescale 1ns/100ps
// host on the register port: one request held up to its taking edge
module tarbc_host (
  input wire logic clock, // system clock
  output tarbc_pkg::tarbc_req_t req, // register request
  input wire logic [15:0] rdata, // read data
  input wire logic rvalid // read data valid
);
  initial req = '0;
  // one write; reserved bit and reset register kept legal
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    if (a == tarbc_pkg::addr_reference_control) d[5] = 1'h0;
    if (a == tarbc_pkg::addr_soft_reset_control)
      d = tarbc_pkg::soft_reset_code;
    @(posedge clock);
    req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask
  // one read; data taken one cycle after the taking edge
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clock);
    req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'h0};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
    d = rvalid ? rdata : 16'hdead;
  endtask
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  tarbc_pkg::tarbc_req_t req;
  tarbc_pkg::tarbc_queue_t queue = '0;
  logic conversion_start = 1'h0;
  logic [8:0] new_data_in = 9'h0;
  logic result_ready_in = 1'h0;
  logic [15:0] rdata, d;
  logic rvalid, queue_mode, queue_pointer_clear, queue_run_select;
  logic queue_trigger, internal_reference_on, internal_reference_level;
  logic reference_settled, result_ready_flag;
  logic [6:0] queue_trigger_level;
  logic [8:0] new_data_valid;
  int n_mismatch = 0;
  int comparisons = 0;
  touch_adc_buffer_ref_ctrl dut (.clock, .resetn, .req, .rdata, .rvalid,
    .queue, .conversion_start, .new_data_in, .result_ready_in, .queue_mode,
    .queue_pointer_clear, .queue_run_select, .queue_trigger_level,
    .queue_trigger, .internal_reference_on, .internal_reference_level,
    .reference_settled, .new_data_valid, .result_ready_flag);
  tarbc_host host (.clock, .req, .rdata, .rvalid);
  // 200 MHz clock
  always #2.5 clock = ~clock;
  // compares and counts
  task automatic chk(input logic [15:0] s, e, input string m);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // register values after reset, unmapped address
  task automatic t_defaults();
    host.rd(6'h02, d);
    chk(d, 16'h0200, "buffer default");
    host.rd(6'h03, d);
    chk(d, 16'h0002, "reference default");
    host.rd(6'h04, d);
    chk(d, 16'hffff, "reset reg default");
    host.rd(6'h05, d);
    chk(d, 16'h0, "unmapped read");
    $display("test defaults done");
  endtask
  // every depth code, then full, not empty, disabled
  task automatic t_queue();
    for (int c = 0; c < 8; c++) begin
      host.wr(6'h02, {2'h3, c[2:0], 11'h7ff});
      #1;
      chk({9'h0, queue_trigger_level}, 16'(8 * (c + 1)), "depth");
      host.rd(6'h02, d);
      chk(d, {2'h3, c[2:0], 11'h200}, "buffer readback");
    end
    @(posedge clock) queue <= '{unread_count: 7'h40};
    host.rd(6'h02, d);
    chk(d, 16'hfc00, "full flag");
    chk({15'h0, queue_trigger}, 16'h1, "trigger at depth");
    chk({15'h0, queue_mode}, 16'h1, "queue on");
    chk({15'h0, queue_run_select}, 16'h1, "single shot");
    @(posedge clock) queue <= '{unread_count: 7'h3f};
    host.rd(6'h02, d);
    chk(d, 16'hf800, "neither flag");
    chk({15'h0, queue_trigger}, 16'h0, "below depth");
    host.wr(6'h02, 16'h0);
    #1;
    chk({15'h0, queue_pointer_clear}, 16'h1, "pointers held");
    host.rd(6'h02, d);
    chk(d, 16'h0200, "disabled reads empty");
    @(posedge clock) queue <= '0;
    $display("test queue done");
  endtask
  // reference modes and power states
  task automatic t_reference();
    host.wr(6'h03, 16'hffff);
    host.rd(6'h03, d);
    chk(d, 16'h001f, "reference readback");
    chk({15'h0, internal_reference_level}, 16'h1, "level");
    chk({15'h0, internal_reference_on}, 16'h0, "sleeping");
    host.wr(6'h03, 16'h0010);
    #1;
    chk({15'h0, internal_reference_on}, 16'h1, "kept on");
    host.wr(6'h03, 16'h0002);
    @(posedge clock) conversion_start <= 1'h1;
    #1;
    chk({15'h0, internal_reference_on}, 16'h0, "external off");
    chk({15'h0, reference_settled}, 16'h1, "no delay");
    @(posedge clock) conversion_start <= 1'h0;
    $display("test reference done");
  endtask
  // 100 us settling after power-up of a sleeping reference
  task automatic t_settle();
    host.wr(6'h03, 16'h0016);
    @(posedge clock) conversion_start <= 1'h1;
    #1;
    chk({15'h0, internal_reference_on}, 16'h1, "powered");
    @(posedge clock) conversion_start <= 1'h0;
    repeat (tarbc_pkg::settle_cycles_1 - 20) @(posedge clock);
    #1;
    chk({15'h0, reference_settled}, 16'h0, "still settling");
    repeat (40) @(posedge clock);
    #1;
    chk({15'h0, reference_settled}, 16'h1, "settled");
    // code 10 still settling where code 01 has finished, then cut short
    host.wr(6'h03, 16'h001a);
    @(posedge clock) conversion_start <= 1'h1;
    @(posedge clock) conversion_start <= 1'h0;
    repeat (tarbc_pkg::settle_cycles_1 + 20) @(posedge clock);
    #1;
    chk({15'h0, reference_settled}, 16'h0, "longer code");
    host.wr(6'h03, 16'h0010);
    #1;
    chk({15'h0, reference_settled}, 16'h1, "awake no delay");
    // code 00 gives no delay at all
    host.wr(6'h03, 16'h0012);
    @(posedge clock) conversion_start <= 1'h1;
    #1;
    chk({15'h0, reference_settled}, 16'h1, "code zero");
    @(posedge clock) conversion_start <= 1'h0;
    $display("test settle done");
  endtask
  // soft reset code, then masking of status
  task automatic t_soft();
    host.wr(6'h02, 16'hc800);
    host.wr(6'h03, 16'h0011);
    host.wr(6'h04, 16'hbb00);
    host.rd(6'h02, d);
    chk(d, 16'h0200, "buffer reset");
    host.rd(6'h03, d);
    chk(d, 16'h0002, "reference reset");
    chk({15'h0, queue_run_select}, 16'h0, "continuous");
    chk({15'h0, internal_reference_on}, 16'h0, "external default");
    @(posedge clock) new_data_in <= 9'h1a5;
    result_ready_in <= 1'h1;
    #1;
    chk({7'h0, new_data_valid}, 16'h01a5, "status passed");
    chk({15'h0, result_ready_flag}, 16'h1, "ready passed");
    host.wr(6'h02, 16'h8000);
    #1;
    chk({7'h0, new_data_valid}, 16'h0, "status masked");
    chk({15'h0, result_ready_flag}, 16'h0, "ready masked");
    $display("test soft reset done");
  endtask
  // counts and verdict
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'h1;
    t_defaults();
    t_queue();
    t_reference();
    t_settle();
    t_soft();
    print_verdict();
  end
  // watchdog, well past the expected run length
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
endmodule
